// *** design/config_loader.sv ***
// Purpose: Walks the nonvolatile locations and strobes each into the registers
// Assumes: Core writes the register at loadIdx while loadValid is high
// Notes:   One location per cycle, ascending, done after the last
`timescale 1ns/10ps
module config_loader
	import supervisor_pkg::*;
(
	// Clock and reset
	input wire logic            clk,
	input wire logic            rst,
	// Sequencer side of the carrier
	supervisor_cfg_if.loader    cfg
);
	logic running;

	assign cfg.loadValid = running;

	always_ff @(posedge clk) begin
		if (rst) begin
			running     <= 1'b0;
			cfg.loadIdx  <= 4'h0;
			cfg.loadDone <= 1'b0;
		end else if (cfg.loadStart) begin
			running     <= 1'b1;
			cfg.loadIdx  <= 4'h0;
			cfg.loadDone <= 1'b0;
		end else if (running) begin
			if (cfg.loadIdx == LAST_REG_IDX) begin
				running     <= 1'b0;
				cfg.loadDone <= 1'b1;
			end else begin
				cfg.loadIdx <= cfg.loadIdx + 4'h1;
			end
		end
	end

	a_load_done_time: assert property (@(posedge clk) disable iff (rst)
		cfg.loadStart |=> !cfg.loadDone [*8] ##1 !cfg.loadDone [*7] ##1 cfg.loadDone)
		else $error("copy did not finish on the sixteenth cycle");
	a_load_ascending: assert property (@(posedge clk) disable iff (rst)
		(running && $past(running) && !$past(cfg.loadStart)) |->
		cfg.loadIdx == $past(cfg.loadIdx) + 4'h1)
		else $error("copy index did not step up by one");
	c_copy_done: cover property (@(posedge clk) disable iff (rst) $rose(cfg.loadDone));
endmodule : config_loader

// *** design/prog_output_logic.sv ***
// Purpose: Condition evaluation, hold timing and pin drive of the outputs
// Assumes: Conditions and fault levels arrive synchronised to clk
// Notes:   Weak-low state is held until the configuration copy is done
`timescale 1ns/10ps
module prog_output_logic
	import supervisor_pkg::*;
(
	// Clock and reset
	input  wire logic           clk,
	input  wire logic           rst,
	// Configuration
	supervisor_cfg_if.outputs   cfg,
	// Condition sources
	input  wire logic [7:0]     detectorBelow,
	input  wire logic [3:0]     gpiActive,
	input  wire logic           watchdogFault,
	// Output pins
	output logic [1:0]          progOutput,
	output logic [1:0]          progOutputOe,
	output logic                progOutputWeakLow
);
	logic [1:0] asserted;
	logic [1:0] cond;

	assign progOutputWeakLow = ~cfg.outputsEnabled;

	for (genvar i = 0; i < 2; i++) begin : g_out
		logic [11:0] holdCnt;
		logic [2:0]  code;
		logic        level;

		assign code = cfg.timing[i][TIM_CODE_LSB +: 3];
		assign cond[i] = (|(cfg.condA[i] & detectorBelow))
			| (|(cfg.condB[i][3:0] & gpiActive))
			| (cfg.condB[i][COND_B_WDOG_BIT] & watchdogFault);
		assign level = cfg.timing[i][TIM_POL_BIT] ? asserted[i] : ~asserted[i];

		always_ff @(posedge clk) begin
			if (rst || !cfg.outputsEnabled) begin
				holdCnt     <= 12'h000;
				asserted[i] <= 1'b0;
			end else if (cond[i]) begin
				holdCnt     <= TIMEOUT_UNIT << code;
				asserted[i] <= 1'b1;
			end else if (holdCnt != 12'h000) begin
				holdCnt <= holdCnt - 12'h001;
			end else begin
				asserted[i] <= 1'b0;
			end
		end

		always_ff @(posedge clk) begin
			if (rst || !cfg.outputsEnabled) begin
				progOutput[i]   <= 1'b0;
				progOutputOe[i] <= 1'b0;
			end else begin
				progOutput[i]   <= cfg.timing[i][TIM_OD_BIT] ? 1'b0 : level;
				progOutputOe[i] <= cfg.timing[i][TIM_OD_BIT] ? ~level : 1'b1;
			end
		end
	end

	a_weak_low_hold: assert property (@(posedge clk) disable iff (rst)
		!cfg.outputsEnabled |-> progOutputWeakLow ##1 (progOutputOe == 2'b00))
		else $error("output driven before the copy finished");
	a_manual_reset: assert property (@(posedge clk) disable iff (rst)
		(cfg.outputsEnabled && |(cfg.condB[0][3:0] & gpiActive)) [*2] |-> asserted[0])
		else $error("held input did not keep the output asserted");
	c_out_asserted: cover property (@(posedge clk) disable iff (rst) $rose(asserted[0]));
endmodule : prog_output_logic

// *** design/supervisor_cfg_if.sv ***
// Purpose: Carrier between the core, the download sequencer and the output logic
// Assumes: Single clock domain
// Notes:   Core drives the register views, loader drives the copy strobes
`timescale 1ns/10ps
interface supervisor_cfg_if;
	logic             loadStart;
	logic             loadValid;
	logic [3:0]       loadIdx;
	logic             loadDone;
	logic             outputsEnabled;
	logic [1:0][7:0]  condA;
	logic [1:0][7:0]  condB;
	logic [1:0][7:0]  timing;

	modport loader (input loadStart, output loadValid, output loadIdx, output loadDone);
	modport core (output loadStart, input loadValid, input loadIdx, input loadDone,
		output outputsEnabled, output condA, output condB, output timing);
	modport outputs (input outputsEnabled, input condA, input condB, input timing);
endinterface : supervisor_cfg_if

// *** design/supervisor_config_download.sv ***
// Purpose: Serial-programmed supervisor core with power-up configuration copy
// Assumes: Open-drain serial pins, analog comparators outside, rst is power-good
// Notes:   Rule summary below
// Summary of operation
// - Start configuration copy above lockout point
// - Refuse serial transfers until copy completes
// - Outputs follow programmed conditions above lockout
// - Missing watchdog input toggle asserts dependent outputs
// - Held general input keeps dependent output asserted
// - Register writes apply within five microseconds
// - Threshold changes apply after settle interval
// - Nonvolatile writes leave volatile registers alone
// - Register N loads from location N plus 80h
// - Registers 00h-07h hold detector thresholds
// - 08h selects range, 09h high impedance
// - 0Ah-0Ch configure first output
// - 0Dh-0Eh select second output conditions
// - Command C4h reboots and recopies configuration
// - Refuse commands outside valid address ranges
// - Refuse commands while internal operation busy
`timescale 1ns/10ps
module supervisor_config_download
	import supervisor_pkg::*;
#(
	parameter logic [15:0] THR_SETTLE_CYCLES   = 16'(THR_SETTLE_CYCLES_DEF),
	parameter logic [31:0] WDOG_TIMEOUT_CYCLES = 32'(WDOG_TIMEOUT_CYCLES_DEF)
)(
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rst,
	// Supply monitor and address straps
	input  wire logic             supplyAboveLockout,
	input  wire logic [1:0]       addrPin,
	// Serial pins
	input  wire logic             sclIn,
	input  wire logic             sdaIn,
	output logic                  sdaOut,
	output logic                  sdaOe,
	// General-purpose inputs and watchdog source
	input  wire logic [3:0]       generalPurposeInput,
	input  wire logic             watchdogSourceEnable,
	input  wire logic [1:0]       watchdogSourceSel,
	// Detector comparators
	input  wire logic [7:0]       detectorBelow,
	output logic [7:0][7:0]       activeThreshold,
	output logic [7:0]            activeRange,
	output logic [7:0]            activeHighZ,
	// Programmable outputs
	output logic [1:0]            progOutput,
	output logic [1:0]            progOutputOe,
	output logic                  progOutputWeakLow
);
	typedef enum {ST_IDLE, ST_ADDR, ST_CMD, ST_DATA, ST_READ, ST_RACK, ST_IGNORE} state_t;

	supervisor_cfg_if cfg ();

	logic [PIN_W-1:0]       pinRaw, pinS1, pinS2, pinS3, pinF;
	logic                   sclPrev, sdaPrev, sclF, sdaF;
	logic                   sclRise, sclFall, startCond, stopCond;
	state_t                 state;
	logic [3:0]             bitCnt;
	logic [7:0]             shiftIn, txByte, ptr, readData;
	logic                   ackPhase, rw, masterAck;
	logic [REG_COUNT-1:0][7:0] regs;
	logic [REG_COUNT-1:0][7:0] nvMem;
	logic [11:0]            nvBusyCnt;
	logic                   busy, ready, supplyPrev;
	logic                   cmdOk, cmdAccept, dataWrite, readLoad, byteDone, addrMatch;
	logic [7:0]             nvOffset;
	logic [15:0]            settleCnt;
	logic                   thrChanged;
	logic [3:0]             gpiActive;
	logic                   wdLevel, wdPrev, wdFault;
	logic [31:0]            wdCnt;

	// Three-stage pin synchronisers with agreement filter
	assign pinRaw = {generalPurposeInput, addrPin, supplyAboveLockout, sdaIn, sclIn};
	for (genvar p = 0; p < PIN_W; p++) begin : g_sync
		always_ff @(posedge clk) begin
			if (rst) begin
				pinS1[p] <= PIN_RESET[p];
				pinS2[p] <= PIN_RESET[p];
				pinS3[p] <= PIN_RESET[p];
				pinF[p]  <= PIN_RESET[p];
			end else begin
				pinS1[p] <= pinRaw[p];
				pinS2[p] <= pinS1[p];
				pinS3[p] <= pinS2[p];
				if (pinS2[p] == pinS3[p])
					pinF[p] <= pinS3[p];
			end
		end
	end

	assign sclF      = pinF[PIN_SCL];
	assign sdaF      = pinF[PIN_SDA];
	assign gpiActive = pinF[PIN_GPI0 +: 4];
	assign sclRise   = sclF & ~sclPrev;
	assign sclFall   = ~sclF & sclPrev;
	assign startCond = sclF & sclPrev & sdaPrev & ~sdaF;
	assign stopCond  = sclF & sclPrev & ~sdaPrev & sdaF;
	assign sdaOut    = 1'b0;

	always_ff @(posedge clk) begin
		if (rst) begin
			sclPrev    <= 1'b1;
			sdaPrev    <= 1'b1;
			supplyPrev <= 1'b0;
		end else begin
			sclPrev    <= sclF;
			sdaPrev    <= sdaF;
			supplyPrev <= pinF[PIN_SUPPLY];
		end
	end

	// Copy start on supply rise or reboot command
	assign cfg.loadStart = (pinF[PIN_SUPPLY] & ~supplyPrev)
		| (cmdAccept & (shiftIn == CMD_REBOOT));
	assign ready = cfg.loadDone & pinF[PIN_SUPPLY];
	assign cfg.outputsEnabled = ready;
	assign busy = ~ready | cfg.loadValid | (nvBusyCnt != 12'h000);

	// Command and address checks
	assign addrMatch = (shiftIn[7:4] == SLAVE_ADDR_HIGH) && (shiftIn[3:2] == pinF[PIN_ADDR0 +: 2]);
	assign cmdOk = ~busy && ((shiftIn <= VOL_LAST)
		|| (shiftIn >= NV_BASE && shiftIn <= NV_LAST)
		|| (shiftIn == CMD_REBOOT));
	assign byteDone  = sclFall & ~ackPhase & (bitCnt == 4'h8);
	assign cmdAccept = byteDone & (state == ST_CMD) & cmdOk;
	assign dataWrite = byteDone & (state == ST_DATA);
	assign readLoad  = sclFall & ((ackPhase & (state == ST_ADDR) & rw)
		| ((state == ST_RACK) & masterAck));
	assign nvOffset  = ptr - NV_BASE;

	always_comb begin
		readData = 8'h00;
		if (ptr <= VOL_LAST)
			readData = regs[ptr[3:0]];
		else if (ptr >= NV_BASE && ptr <= NV_MAPPED_LAST)
			readData = nvMem[nvOffset[3:0]];
	end

	// Serial slave bit engine
	always_ff @(posedge clk) begin
		if (rst) begin
			state     <= ST_IDLE;
			bitCnt    <= 4'h0;
			shiftIn   <= 8'h00;
			txByte    <= 8'h00;
			ackPhase  <= 1'b0;
			sdaOe     <= 1'b0;
			rw        <= 1'b0;
			masterAck <= 1'b0;
		end else if (startCond) begin
			state    <= ST_ADDR;
			bitCnt   <= 4'h0;
			ackPhase <= 1'b0;
			sdaOe    <= 1'b0;
		end else if (stopCond) begin
			state    <= ST_IDLE;
			ackPhase <= 1'b0;
			sdaOe    <= 1'b0;
		end else if (sclRise) begin
			case (state)
				ST_ADDR, ST_CMD, ST_DATA: begin
					if (!ackPhase) begin
						shiftIn <= {shiftIn[6:0], sdaF};
						bitCnt  <= bitCnt + 4'h1;
					end
				end
				ST_READ: bitCnt <= bitCnt + 4'h1;
				ST_RACK: masterAck <= ~sdaF;
				default: ;
			endcase
		end else if (sclFall) begin
			if (ackPhase) begin
				ackPhase <= 1'b0;
				sdaOe    <= 1'b0;
				bitCnt   <= 4'h0;
				case (state)
					ST_ADDR: begin
						if (rw) begin
							state  <= ST_READ;
							txByte <= readData;
							sdaOe  <= ~readData[7];
						end else begin
							state <= ST_CMD;
						end
					end
					ST_CMD:  state <= ST_DATA;
					default: ;
				endcase
			end else if (byteDone && state == ST_ADDR) begin
				rw <= shiftIn[0];
				if (addrMatch && ready) begin
					ackPhase <= 1'b1;
					sdaOe    <= 1'b1;
				end else begin
					state <= ST_IGNORE;
				end
			end else if (byteDone && state == ST_CMD) begin
				if (cmdOk) begin
					ackPhase <= 1'b1;
					sdaOe    <= 1'b1;
				end else begin
					state <= ST_IGNORE;
				end
			end else if (byteDone && state == ST_DATA) begin
				ackPhase <= 1'b1;
				sdaOe    <= 1'b1;
			end else if (state == ST_READ) begin
				if (bitCnt == 4'h8) begin
					sdaOe <= 1'b0;
					state <= ST_RACK;
				end else begin
					sdaOe <= ~txByte[3'(4'h7 - bitCnt)];
				end
			end else if (state == ST_RACK) begin
				if (masterAck) begin
					state  <= ST_READ;
					bitCnt <= 4'h0;
					txByte <= readData;
					sdaOe  <= ~readData[7];
				end else begin
					state <= ST_IGNORE;
				end
			end
		end
	end

	// Address pointer, held at the end of each region
	always_ff @(posedge clk) begin
		if (rst) begin
			ptr <= 8'h00;
		end else if (cmdAccept && shiftIn != CMD_REBOOT) begin
			ptr <= shiftIn;
		end else if ((dataWrite || readLoad) && ptr != VOL_LAST && ptr != NV_LAST) begin
			ptr <= ptr + 8'h01;
		end
	end

	// Volatile registers: copy strobes and host writes
	always_ff @(posedge clk) begin
		if (rst) begin
			regs <= '0;
		end else if (cfg.loadValid) begin
			regs[cfg.loadIdx] <= nvMem[cfg.loadIdx];
		end else if (dataWrite && ptr <= VOL_LAST) begin
			regs[ptr[3:0]] <= shiftIn;
		end
	end

	// Nonvolatile locations, only mirrored by a copy
	always_ff @(posedge clk) begin
		if (rst) begin
			nvMem     <= {REG_COUNT{NV_ERASED}};
			nvBusyCnt <= 12'h000;
		end else if (dataWrite && ptr >= NV_BASE) begin
			if (ptr <= NV_MAPPED_LAST)
				nvMem[nvOffset[3:0]] <= shiftIn;
			nvBusyCnt <= NVM_WRITE_CYCLES;
		end else if (nvBusyCnt != 12'h000) begin
			nvBusyCnt <= nvBusyCnt - 12'h001;
		end
	end

	// Register views for the output logic
	assign cfg.condA[0]  = regs[REG_OUT1_COND_A];
	assign cfg.condB[0]  = regs[REG_OUT1_COND_B];
	assign cfg.timing[0] = regs[REG_OUT1_TIMING];
	assign cfg.condA[1]  = regs[REG_OUT2_COND_A];
	assign cfg.condB[1]  = regs[REG_OUT2_COND_B];
	assign cfg.timing[1] = OUT2_TIMING;

	// Range and high-Z apply one cycle after the write
	always_ff @(posedge clk) begin
		if (rst) begin
			activeRange <= 8'h00;
			activeHighZ <= 8'h00;
		end else begin
			activeRange <= regs[REG_RANGE];
			activeHighZ <= regs[REG_HIGHZ];
		end
	end

	// Thresholds apply only after the settle interval
	assign thrChanged = (dataWrite && ptr <= REG_THR_LAST)
		|| (cfg.loadValid && {4'h0, cfg.loadIdx} <= REG_THR_LAST);

	always_ff @(posedge clk) begin
		if (rst) begin
			settleCnt       <= 16'h0000;
			activeThreshold <= '0;
		end else if (thrChanged) begin
			settleCnt <= THR_SETTLE_CYCLES;
		end else if (settleCnt == 16'h0001) begin
			settleCnt       <= 16'h0000;
			activeThreshold <= regs[7:0];
		end else if (settleCnt != 16'h0000) begin
			settleCnt <= settleCnt - 16'h0001;
		end
	end

	// Watchdog on a selected general-purpose input
	assign wdLevel = gpiActive[watchdogSourceSel];

	always_ff @(posedge clk) begin
		if (rst || !ready || !watchdogSourceEnable) begin
			wdPrev  <= wdLevel;
			wdCnt   <= 32'h0000_0000;
			wdFault <= 1'b0;
		end else if (wdLevel != wdPrev) begin
			wdPrev  <= wdLevel;
			wdCnt   <= 32'h0000_0000;
			wdFault <= 1'b0;
		end else if (wdCnt == WDOG_TIMEOUT_CYCLES - 32'h1) begin
			wdFault <= 1'b1;
		end else begin
			wdCnt <= wdCnt + 32'h1;
		end
	end

	config_loader u_loader (
		.clk (clk),
		.rst (rst),
		.cfg (cfg)
	);

	prog_output_logic u_outputs (
		.clk               (clk),
		.rst               (rst),
		.cfg               (cfg),
		.detectorBelow     (detectorBelow),
		.gpiActive         (gpiActive),
		.watchdogFault     (wdFault),
		.progOutput        (progOutput),
		.progOutputOe      (progOutputOe),
		.progOutputWeakLow (progOutputWeakLow)
	);

	a_addr_busy_nack: assert property (@(posedge clk) disable iff (rst)
		(byteDone && state == ST_ADDR && !ready) |=> !sdaOe && state == ST_IGNORE)
		else $error("address acknowledged before the copy finished");
	a_cmd_refused: assert property (@(posedge clk) disable iff (rst)
		(byteDone && state == ST_CMD && (busy || shiftIn == 8'h50)) |=> !ackPhase)
		else $error("invalid or busy command acknowledged");
	a_nv_keeps_regs: assert property (@(posedge clk) disable iff (rst)
		(dataWrite && ptr >= NV_BASE && !cfg.loadValid) |=> regs == $past(regs))
		else $error("nonvolatile write changed a register");
	a_copy_mirror: assert property (@(posedge clk) disable iff (rst)
		cfg.loadValid |=> regs[$past(cfg.loadIdx)] == $past(nvMem[cfg.loadIdx]))
		else $error("register not loaded from its mirror location");
	a_range_latency: assert property (@(posedge clk) disable iff (rst)
		##1 activeRange == $past(regs[REG_RANGE]) && activeHighZ == $past(regs[REG_HIGHZ]))
		else $error("range or high-Z not applied on the next cycle");
	a_thr_settle: assert property (@(posedge clk) disable iff (rst)
		$changed(activeThreshold) |-> $past(settleCnt) == 16'h0001)
		else $error("threshold applied before the settle interval");
	a_reboot_copy: assert property (@(posedge clk) disable iff (rst)
		(cmdAccept && shiftIn == CMD_REBOOT) |=> cfg.loadValid && !cfg.loadDone)
		else $error("reboot command did not restart the copy");
	a_wdog_expiry: assert property (@(posedge clk) disable iff (rst)
		(ready && watchdogSourceEnable && wdLevel == wdPrev && $stable(wdLevel)
		&& wdCnt == WDOG_TIMEOUT_CYCLES - 32'h1) |=> wdFault)
		else $error("watchdog did not fault after the timeout");
	c_reg_write: cover property (@(posedge clk) disable iff (rst) dataWrite && ptr <= VOL_LAST);
	c_read_byte: cover property (@(posedge clk) disable iff (rst) readLoad);
	c_wdog_fault: cover property (@(posedge clk) disable iff (rst) $rose(wdFault));
endmodule : supervisor_config_download

// *** design/supervisor_pkg.sv ***
// Purpose: Shared constants for the supervisor configuration download block
// Assumes: 200 MHz core clock, registers 00h..0Eh and their nonvolatile mirrors
// Notes:   Apply and settle times are kept in ns and their cycle counts derived; watchdog and NV write are given in cycles
package supervisor_pkg;
	localparam int          CLK_MHZ         = 200;
	localparam int          REG_COUNT       = 15;
	localparam logic [3:0]  LAST_REG_IDX    = 4'he;
	localparam logic [7:0]  VOL_LAST        = 8'h0e;
	localparam logic [7:0]  NV_BASE         = 8'h80;
	localparam logic [7:0]  NV_LAST         = 8'hb7;
	localparam logic [7:0]  NV_MAPPED_LAST  = 8'h8e;
	localparam logic [7:0]  CMD_REBOOT      = 8'hc4;
	localparam logic [7:0]  NV_ERASED       = 8'h00;
	// Register offsets
	localparam logic [7:0]  REG_THR_LAST    = 8'h07;
	localparam logic [3:0]  REG_RANGE       = 4'h8;
	localparam logic [3:0]  REG_HIGHZ       = 4'h9;
	localparam logic [3:0]  REG_OUT1_COND_A = 4'ha;
	localparam logic [3:0]  REG_OUT1_COND_B = 4'hb;
	localparam logic [3:0]  REG_OUT1_TIMING = 4'hc;
	localparam logic [3:0]  REG_OUT2_COND_A = 4'hd;
	localparam logic [3:0]  REG_OUT2_COND_B = 4'he;
	// Timing and condition register fields
	localparam int          TIM_CODE_LSB    = 0;
	localparam int          TIM_POL_BIT     = 3;
	localparam int          TIM_OD_BIT      = 4;
	localparam int          COND_B_WDOG_BIT = 4;
	localparam logic [7:0]  OUT2_TIMING     = 8'h00;
	localparam logic [11:0] TIMEOUT_UNIT    = 12'h010;
	// Serial slave address: upper nibble fixed, two strap bits
	localparam logic [3:0]  SLAVE_ADDR_HIGH = 4'ha;
	// Synchronised pin vector layout
	localparam int          PIN_SCL         = 0;
	localparam int          PIN_SDA         = 1;
	localparam int          PIN_SUPPLY      = 2;
	localparam int          PIN_ADDR0       = 3;
	localparam int          PIN_GPI0        = 5;
	localparam int          PIN_W           = 9;
	localparam logic [8:0]  PIN_RESET       = 9'h003;
	// Timing
	localparam int          APPLY_LATENCY_NS       = 5000;
	localparam int          APPLY_LATENCY_CYCLES   = APPLY_LATENCY_NS * CLK_MHZ / 1000;
	localparam int          THR_SETTLE_NS          = 150000;
	localparam int          THR_SETTLE_CYCLES_DEF  = THR_SETTLE_NS * CLK_MHZ / 1000;
	localparam int          WDOG_TIMEOUT_CYCLES_DEF = 20000;
	localparam logic [11:0] NVM_WRITE_CYCLES       = 12'h3e8;
endpackage : supervisor_pkg

// *** tb/serial_host_model.sv ***
// Purpose: Two-wire host that frames transfers to the supervisor
// Assumes: Open-drain data line with pull-up resolved by the bench
// Notes:   Each bit holds SCL low for 2H clocks and high for H clocks; signals move only after clk edges
`timescale 1ns/10ps
module serial_host_model
	import supervisor_pkg::*;
#(
	parameter int H = 8
)(
	// Clock
	input  wire logic       clk,
	// Bus lines
	input  wire logic       sdaWire,
	input  wire logic [1:0] addrStrap,
	output logic            scl,
	output logic            sdaLow
);
	initial begin
		scl = 1'b1;
		sdaLow = 1'b0;
	end
	task automatic hold(input int n);
		repeat (n) @(posedge clk);
	endtask : hold
	task automatic bitx(input logic b, output logic r);
		hold(H);
		sdaLow <= ~b;
		hold(H);
		scl <= 1'b1;
		hold(H);
		r = sdaWire;
		scl <= 1'b0;
	endtask : bitx
	// Also serves as repeated start
	task automatic start();
		hold(H);
		sdaLow <= 1'b0;
		hold(H);
		scl <= 1'b1;
		hold(H);
		sdaLow <= 1'b1;
		hold(H);
		scl <= 1'b0;
	endtask : start
	task automatic stop();
		hold(H);
		sdaLow <= 1'b1;
		hold(H);
		scl <= 1'b1;
		hold(H);
		sdaLow <= 1'b0;
		hold(H);
	endtask : stop
	task automatic xbyte(input logic [7:0] d, input logic last, output logic [7:0] r,
		output logic ack);
		logic a;
		for (int i = 7; i >= 0; i--) bitx(d[i], r[i]);
		bitx(last, a);
		ack = ~a;
	endtask : xbyte
	task automatic wrFrame(input logic [7:0] cmd, input logic [7:0] dat[$],
		output logic [1:0] acks);
		logic [7:0] r;
		logic       a;
		acks = 2'b00;
		start();
		xbyte({SLAVE_ADDR_HIGH, addrStrap, 2'b00}, 1'b1, r, acks[1]);
		if (acks[1]) xbyte(cmd, 1'b1, r, acks[0]);
		if (acks[0]) foreach (dat[i]) xbyte(dat[i], 1'b1, r, a);
		stop();
	endtask : wrFrame
	task automatic rdFrame(input int n, output logic [7:0] v[$]);
		logic [7:0] r;
		logic       a;
		v = {};
		start();
		xbyte({SLAVE_ADDR_HIGH, addrStrap, 2'b01}, 1'b1, r, a);
		for (int i = 0; i < n; i++) begin
			xbyte(8'hff, i == n - 1, r, a);
			v.push_back(r);
		end
		stop();
	endtask : rdFrame
	// Busy refusal is retried until the address is taken, for at most 20 attempts
	task automatic waitReady();
		logic [7:0] r;
		logic       ok;
		ok = 1'b0;
		repeat (20) begin
			if (!ok) begin
				start();
				xbyte({SLAVE_ADDR_HIGH, addrStrap, 2'b00}, 1'b1, r, ok);
				stop();
			end
		end
	endtask : waitReady
endmodule : serial_host_model

// *** tb/tb.sv ***
// Purpose: Self-checking bench for the configuration download block
// Assumes: Host model on the serial pins, bench drives general inputs
// Notes:   Read bytes are checked against a queue of expected values
`timescale 1ns/10ps
module tb;
	import supervisor_pkg::*;
	logic            clk, rst, supply, scl, sdaWire, sdaOut, sdaOe, hostLow, wdEn, weakLow;
	logic [1:0]      addrPin, wdSel, progOutput, progOutputOe, acks;
	logic [3:0]      gpi;
	logic [7:0]      below, activeRange, activeHighZ, v;
	logic [7:0][7:0] activeThreshold;
	logic [7:0]      expQ[$], gotQ[$], regs[$], nvd[$], rd[$], none[$], zero[$];
	int              n_mismatch, n_compared;
	assign sdaWire = ~((sdaOe & ~sdaOut) | hostLow);
	supervisor_config_download #(.THR_SETTLE_CYCLES(16'd20), .WDOG_TIMEOUT_CYCLES(32'd50))
	i_supervisor_config_download (.clk(clk), .rst(rst), .supplyAboveLockout(supply),
		.addrPin(addrPin), .sclIn(scl), .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe),
		.generalPurposeInput(gpi), .watchdogSourceEnable(wdEn), .watchdogSourceSel(wdSel),
		.detectorBelow(below), .activeThreshold(activeThreshold), .activeRange(activeRange),
		.activeHighZ(activeHighZ), .progOutput(progOutput), .progOutputOe(progOutputOe),
		.progOutputWeakLow(weakLow));
	serial_host_model i_serial_host_model (.clk(clk), .sdaWire(sdaWire), .addrStrap(addrPin),
		.scl(scl), .sdaLow(hostLow));
	always #2.5 clk = ~clk;
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic results();
		if (n_mismatch == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : results
	task automatic readRegs(input logic [7:0] base, input logic [7:0] exp[$]);
		i_serial_host_model.wrFrame(base, none, acks);
		foreach (exp[i]) expQ.push_back(exp[i]);
		i_serial_host_model.rdFrame(exp.size(), rd);
		foreach (rd[i]) gotQ.push_back(rd[i]);
	endtask : readRegs
	// Pair each returned byte with the oldest expectation
	always @(posedge clk) if (gotQ.size() > 0 && expQ.size() > 0)
		chk(gotQ.pop_front(), expQ.pop_front());
	initial begin
		repeat (60000) @(posedge clk);
		n_mismatch++;
		results();
	end
	initial begin
		v = 8'($urandom(32'h13a08987));
		clk = 1'b0;
		rst = 1'b1;
		supply = 1'b0;
		addrPin = 2'($urandom);
		gpi = 4'h0;
		wdEn = 1'b0;
		wdSel = 2'h1;
		below = 8'h00;
		for (int i = 0; i < 15; i++) begin
			zero.push_back(8'h00);
			regs.push_back(8'($urandom));
			nvd.push_back(8'($urandom));
		end
		regs[10] = 8'h00;
		regs[11] = 8'h01;
		regs[12] = 8'h08;
		regs[13] = 8'h80;
		regs[14] = 8'h10;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		repeat (10) @(posedge clk);
		chk(weakLow, 1'b1);
		i_serial_host_model.wrFrame(8'h00, none, acks);
		chk(acks, 2'b00);
		supply <= 1'b1;
		i_serial_host_model.waitReady();
		chk(weakLow, 1'b0);
		readRegs(8'h00, zero);
		i_serial_host_model.wrFrame(8'h00, regs, acks);
		chk(acks, 2'b11);
		repeat (30) @(posedge clk);
		for (int i = 0; i < 8; i++) chk(activeThreshold[i], regs[i]);
		chk({activeRange, activeHighZ}, {regs[8], regs[9]});
		readRegs(8'h00, regs);
		chk(progOutput, 2'b10);
		gpi[0] <= 1'b1;
		repeat (10) @(posedge clk);
		chk({progOutput[0], progOutputOe[0]}, 2'b11);
		repeat (100) @(posedge clk);
		chk(progOutput[0], 1'b1);
		gpi[0] <= 1'b0;
		wdEn <= 1'b1;
		repeat (70) @(posedge clk);
		chk(progOutput, 2'b00);
		repeat (10) begin
			gpi[1] <= ~gpi[1];
			repeat (20) @(posedge clk);
		end
		chk(progOutput[1], 1'b1);
		below <= 8'h80;
		repeat (5) @(posedge clk);
		chk(progOutput[1], 1'b0);
		below <= 8'h00;
		wdEn <= 1'b0;
		i_serial_host_model.wrFrame(8'h80, nvd, acks);
		chk(acks, 2'b11);
		i_serial_host_model.wrFrame(8'h00, regs, acks);
		chk(acks, 2'b10);
		repeat (1000) @(posedge clk);
		i_serial_host_model.wrFrame(8'h0f, none, acks);
		chk(acks, 2'b10);
		i_serial_host_model.wrFrame(8'hb8, none, acks);
		chk(acks, 2'b10);
		readRegs(8'h00, regs);
		i_serial_host_model.wrFrame(CMD_REBOOT, none, acks);
		chk(acks, 2'b11);
		i_serial_host_model.waitReady();
		readRegs(8'h00, nvd);
		repeat (20) @(posedge clk);
		chk(expQ.size(), 0);
		results();
	end
endmodule : tb
